// ==== design/ispf_pkg.sv ====
package ispf_pkg;
  // Interface instances with this function, channel pairs per instance
  localparam int unsigned I2S_INSTANCES = 2;
  localparam int unsigned CHANNEL_PAIRS = 1;
  // Register byte addresses
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_DATA = 12'h00C;
  // first_config_register fields
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_TX_BIT = 1;
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam int unsigned CFG_LEN_LSB = 16;
  localparam logic [4:0] LEN_RESET = 5'h0F;
  localparam logic [1:0] MODE_I2S = 2'h0;
  localparam logic [1:0] MODE_LJ = 2'h1;
  // Words longer than this lost their top bit on the faulty revision
  localparam logic [4:0] LEN_DEFECT_MAX = 5'h17;
  localparam logic FIX_RX_MSB = 1'b1;
  // fifo_status_register fields
  localparam int unsigned STAT_UNDER_BIT = 0;
  localparam int unsigned STAT_OVER_BIT = 1;
  localparam int unsigned STAT_EMPTY_BIT = 2;
  localparam int unsigned STAT_FULL_BIT = 3;
  localparam int unsigned STAT_CNT_LSB = 8;
  // Shared FIFO
  localparam int unsigned FIFO_AW = 3;
  localparam int unsigned FIFO_DW = 32;

  typedef struct packed {
    logic [4:0] len;
    logic [1:0] mode;
    logic tx;
    logic en;
  } ispf_cfg_type;
endpackage

// ==== design/ispf_top.sv ====
`timescale 1ns/1ps
module ispf_top
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Serial audio link, codec is clock master
  input wire logic I_SCK,
  input wire logic I_WS,
  input wire logic I_SDI,
  output logic O_SDO,
  // Interrupt
  output logic O_IRQ
);

  function automatic logic [31:0] len_mask(input logic [4:0] len);
    len_mask = 32'hFFFFFFFF >> (5'h1F - len);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link synchronisers
  logic sck_s1, sck_s2, sck_d;
  logic ws_s1, ws_s2, ws_d;
  logic sdi_s1, sdi_s2;
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      ws_s1 <= 1'b0;
      ws_s2 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      sck_s1 <= I_SCK;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      ws_s1 <= I_WS;
      ws_s2 <= ws_s1;
      sdi_s1 <= I_SDI;
      sdi_s2 <= sdi_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  ispf_pkg::ispf_cfg_type cfg;
  logic under, over;
  logic [1:0] mask;
  logic [ispf_pkg::FIFO_AW:0] wr_ptr, rd_ptr;
  logic [ispf_pkg::FIFO_DW-1:0] mem [0:(1 << ispf_pkg::FIFO_AW)-1];

  wire acc = I_PSEL & I_PENABLE;
  wire hit_cfg = I_PADDR == ispf_pkg::ADDR_CFG;
  wire hit_stat = I_PADDR == ispf_pkg::ADDR_STAT;
  wire hit_mask = I_PADDR == ispf_pkg::ADDR_MASK;
  wire hit_data = I_PADDR == ispf_pkg::ADDR_DATA;
  wire mapped = hit_cfg | hit_stat | hit_mask | hit_data;
  wire wr_cfg = acc & I_PWRITE & hit_cfg;
  wire wr_stat = acc & I_PWRITE & hit_stat;
  wire wr_mask = acc & I_PWRITE & hit_mask;
  wire wr_data = acc & I_PWRITE & hit_data;
  wire rd_data = acc & ~I_PWRITE & hit_data;

  wire [ispf_pkg::FIFO_AW:0] count = wr_ptr - rd_ptr;
  wire fifo_empty = wr_ptr == rd_ptr;
  wire fifo_full = count[ispf_pkg::FIFO_AW];
  wire [31:0] fifo_out = mem[rd_ptr[ispf_pkg::FIFO_AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing, shared by receive and transmit
  wire sck_rise = sck_s2 & ~sck_d;
  wire sck_fall = ~sck_s2 & sck_d;
  wire ws_edge = sck_rise & (ws_s2 != ws_d);
  wire is_lj = cfg.mode == ispf_pkg::MODE_LJ;
  wire [5:0] len_bits = {1'b0, cfg.len} + 6'h01;
  logic [5:0] cnt;
  wire [5:0] cnt_base = ws_edge ? 6'h00 : cnt;
  // Received left-justified data starts at the select edge; standard mode and all transmit start one bit later
  wire cap = sck_rise & cfg.en & ~cfg.tx & ((ws_edge & is_lj) | (~ws_edge & (cnt < len_bits)));
  wire [5:0] cnt_next = cnt_base + 6'h01;
  wire rx_done = cap & (cnt_next == len_bits);
  logic [31:0] rx_sr;
  wire [31:0] rx_raw = {rx_sr[30:0], sdi_s2} & len_mask(cfg.len);
  wire drop_msb = ~ispf_pkg::FIX_RX_MSB & (cfg.len > ispf_pkg::LEN_DEFECT_MAX);
  wire [31:0] rx_word = drop_msb ? (rx_raw & ~(32'h00000001 << cfg.len)) : rx_raw;

  // One channel pair: select level only marks left or right word
  wire tx_need = ws_edge & cfg.en & cfg.tx;
  wire tx_cnt_adv = sck_rise & cfg.en & cfg.tx & ~ws_edge & (cnt < len_bits);

  ////////////////////////////////////////////////////////////////////////////
  // Shared FIFO: direction decides who fills and who drains
  wire push = cfg.tx ? wr_data : rx_done;
  wire pop = cfg.tx ? tx_need : rd_data;
  wire push_ok = push & ~fifo_full;
  wire pop_ok = pop & ~fifo_empty;
  wire [31:0] push_word = cfg.tx ? I_PWDATA : rx_word;
  wire set_under = tx_need & fifo_empty;
  wire set_over = rx_done & fifo_full;

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push_ok)
        wr_ptr <= wr_ptr + 4'h1;
      if (pop_ok)
        rd_ptr <= rd_ptr + 4'h1;
    end
  end

  // Storage needs no reset; pointers define what is valid
  always_ff @(posedge I_CLOCK)
  begin
    if (push_ok)
      mem[wr_ptr[ispf_pkg::FIFO_AW-1:0]] <= push_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine
  logic [31:0] tx_word;
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      ws_d <= 1'b0;
      cnt <= 6'h00;
      rx_sr <= 32'h00000000;
      tx_word <= 32'h00000000;
      O_SDO <= 1'b0;
    end
    else
    begin
      // Reference follows the pin while disabled, so the first word after enable is framed
      if (sck_rise | ~cfg.en)
        ws_d <= ws_s2;
      if (cap | tx_cnt_adv)
        cnt <= cnt_next;
      else if (ws_edge)
        cnt <= 6'h00;
      if (cap)
        rx_sr <= {rx_sr[30:0], sdi_s2};
      if (tx_need)
        tx_word <= fifo_empty ? 32'h00000000 : fifo_out;
      // Driven on the falling edge so the codec samples a settled bit
      if (sck_fall)
        O_SDO <= cfg.en & cfg.tx & (cnt < len_bits) & tx_word[5'(len_bits - 6'h01 - cnt)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, status, interrupt
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      cfg <= '{len: ispf_pkg::LEN_RESET, mode: ispf_pkg::MODE_I2S, tx: 1'b0, en: 1'b0};
      mask <= 2'h0;
      under <= 1'b0;
      over <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg <= '{len: I_PWDATA[ispf_pkg::CFG_LEN_LSB +: 5], mode: I_PWDATA[ispf_pkg::CFG_MODE_LSB +: 2],
                 tx: I_PWDATA[ispf_pkg::CFG_TX_BIT], en: I_PWDATA[ispf_pkg::CFG_EN_BIT]};
      if (wr_mask)
        mask <= I_PWDATA[1:0];
      // Set wins over a clear in the same cycle
      under <= set_under | (under & ~(wr_stat & I_PWDATA[ispf_pkg::STAT_UNDER_BIT]));
      over <= set_over | (over & ~(wr_stat & I_PWDATA[ispf_pkg::STAT_OVER_BIT]));
    end
  end

  assign O_IRQ = (under & mask[0]) | (over & mask[1]);

  wire [31:0] cfg_rd = ({27'h0, cfg.len} << ispf_pkg::CFG_LEN_LSB) | ({30'h0, cfg.mode} << ispf_pkg::CFG_MODE_LSB)
                     | ({31'h0, cfg.tx} << ispf_pkg::CFG_TX_BIT) | ({31'h0, cfg.en} << ispf_pkg::CFG_EN_BIT);
  wire [31:0] stat_rd = ({28'h0, count} << ispf_pkg::STAT_CNT_LSB) | ({31'h0, fifo_full} << ispf_pkg::STAT_FULL_BIT)
                      | ({31'h0, fifo_empty} << ispf_pkg::STAT_EMPTY_BIT) | ({31'h0, over} << ispf_pkg::STAT_OVER_BIT)
                      | ({31'h0, under} << ispf_pkg::STAT_UNDER_BIT);

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc & (~mapped | (wr_data & (~cfg.tx | fifo_full)) | (rd_data & (cfg.tx | fifo_empty)));
  assign O_PRDATA = hit_cfg ? cfg_rd : hit_stat ? stat_rd : hit_mask ? {30'h0, mask}
                  : (hit_data & ~cfg.tx & ~fifo_empty) ? fifo_out : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_need_empty;
    ws_edge && cfg.en && cfg.tx && fifo_empty;
  endsequence
  sequence s_no_clear;
    !(wr_stat && I_PWDATA[ispf_pkg::STAT_UNDER_BIT]);
  endsequence

  property p_under_set;
    s_need_empty |=> under;
  endproperty
  a_under_set: assert property (p_under_set) else $error("underflow did not set flag");

  property p_under_sticky;
    under ##0 s_no_clear |=> under;
  endproperty
  a_under_sticky: assert property (p_under_sticky) else $error("underrun flag lost");

  property p_irq_level;
    (under && mask[0]) |-> O_IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt low while enabled flag set");

  property p_rx_width;
    rx_done |-> ((rx_word & ~len_mask(cfg.len)) == 32'h00000000);
  endproperty
  a_rx_width: assert property (p_rx_width) else $error("received word wider than length");

  property p_rx_msb;
    rx_done |-> (rx_word[cfg.len] == ((cfg.len == 5'h00) ? sdi_s2 : rx_sr[cfg.len - 5'h01]));
  endproperty
  a_rx_msb: assert property (p_rx_msb) else $error("received MSB altered");

  property p_mode_start;
    (ws_edge && cfg.en && !cfg.tx && !wr_cfg) |=> (cnt == (is_lj ? 6'h01 : 6'h00));
  endproperty
  a_mode_start: assert property (p_mode_start) else $error("word start wrong for mode");

  property p_shared_fill;
    (!cfg.tx && rx_done && !fifo_full && !pop_ok) |=> (count == $past(count) + 4'h1);
  endproperty
  a_shared_fill: assert property (p_shared_fill) else $error("received word not in shared FIFO");

  property p_one_pair;
    cnt <= 6'h20;
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("bit count past one channel word");

endmodule

// ==== sim/ispf_codec.sv ====
`timescale 1ns/1ps
// Codec as link master; bit clock stands still between frames
// Paced by the bench clock so every pin changes by non-blocking assignment at a rising edge
module ispf_codec
(
  // Pacing clock
  input wire logic i_clock,
  // Link
  output logic o_sck,
  output logic o_ws,
  output logic o_sdi,
  input wire logic i_sdo
);
  logic [31:0] got [2];
  initial
  begin
    o_sck <= 1'b0;
    o_ws <= 1'b1;
    o_sdi <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Half of the 200 ns bit period
  task automatic half;
    repeat (4) @(posedge i_clock);
  endtask
  // Two spare slots per half so no word is cut by the next select change
  task automatic frame(input logic [31:0] l, input logic [31:0] r, input int n, input bit lj);
    logic [31:0] w;
    int b;
    for (int ch = 0; ch < 2; ch++)
    begin
      w = (ch == 1) ? r : l;
      got[ch] = 32'h00000000;
      for (int k = 0; k < n + 2; k++)
      begin
        half();
        o_sck <= 1'b0;
        if (k == 0)
          o_ws <= (ch == 1);
        b = lj ? k : k - 1;
        // Outside the word the line toggles, never holds its last bit
        o_sdi <= (b >= 0 && b < n) ? w[n - 1 - b] : ~o_sdi;
        half();
        o_sck <= 1'b1;
        // Data out moved on a detected fall, settled well before this edge
        if (k >= 1 && k <= n)
          got[ch] = {got[ch][30:0], i_sdo};
      end
    end
    half();
    o_sck <= 1'b0;
    o_sdi <= ~o_sdi;
  endtask
endmodule

// ==== sim/ispf_top_tb.sv ====
`timescale 1ns/1ps
module ispf_top_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sck;
  logic ws;
  logic sdi;
  logic sdo;
  logic irq;
  logic [31:0] q;
  logic e;
  logic [4:0] lens [3] = '{5'h17, 5'h18, 5'h1F};
  int n_fail = 0;
  int total_checks = 0;
  initial forever #12.5 clock = ~clock;
  ispf_top DUT (.I_CLOCK(clock), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SCK(sck), .I_WS(ws), .I_SDI(sdi), .O_SDO(sdo), .O_IRQ(irq));
  ispf_codec codec (.i_clock(clock), .o_sck(sck), .o_ws(ws), .o_sdi(sdi), .i_sdo(sdo));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      test_done();
    end
  endtask
  // Interrupt is combinational from registers; let the write land first
  task automatic chk_irq(input logic x);
    #1;
    check({31'h0, irq}, {31'h0, x});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic reg_reset;
    apb(1'b0, ispf_pkg::ADDR_CFG, 32'h0);
    check(q, 32'h000F0000);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check(q, 32'h00000004);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, e}, 32'h00000001);
  endtask
  // Ten words into eight places: the last two are dropped and flagged
  task automatic rx_over;
    apb(1'b1, ispf_pkg::ADDR_CFG, 32'h00070001);
    apb(1'b1, ispf_pkg::ADDR_MASK, 32'h00000002);
    for (int f = 0; f < 5; f++)
      codec.frame(32'h000000A5 + f, 32'h0000005A + f, 8, 1'b0);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check(q, 32'h0000080A);
    chk_irq(1'b1);
    apb(1'b1, ispf_pkg::ADDR_DATA, 32'h00000001);
    check({31'h0, e}, 32'h00000001);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, ispf_pkg::ADDR_DATA, 32'h0);
      check(q, (i % 2 == 1) ? 32'h0000005A + i / 2 : 32'h000000A5 + i / 2);
    end
    apb(1'b0, ispf_pkg::ADDR_DATA, 32'h0);
    check({31'h0, e}, 32'h00000001);
    apb(1'b1, ispf_pkg::ADDR_STAT, 32'h00000002);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check(q, 32'h00000004);
    chk_irq(1'b0);
  endtask
  // Reset in mid-run must return every register to its reset value
  task automatic mid_reset;
    apb(1'b1, ispf_pkg::ADDR_CFG, 32'h001F0007);
    apb(1'b0, ispf_pkg::ADDR_CFG, 32'h0);
    check(q, 32'h001F0007);
    apb(1'b1, ispf_pkg::ADDR_MASK, 32'h00000003);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reg_reset();
    apb(1'b0, ispf_pkg::ADDR_MASK, 32'h0);
    check(q, 32'h00000000);
  endtask
  task automatic rx_len(input logic [4:0] len, input logic [1:0] mode);
    logic [31:0] m;
    m = 32'hFFFFFFFF >> (5'h1F - len);
    apb(1'b1, ispf_pkg::ADDR_CFG, {11'h0, len, 12'h0, mode, 2'h1});
    codec.frame(32'hFFFFFFFF, 32'h8135A5A5, int'(len) + 1, mode == ispf_pkg::MODE_LJ);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check({28'h0, q[11:8]}, 32'h00000002);
    apb(1'b0, ispf_pkg::ADDR_DATA, 32'h0);
    check(q, m);
    apb(1'b0, ispf_pkg::ADDR_DATA, 32'h0);
    check(q, 32'h8135A5A5 & m);
  endtask
  task automatic tx_under;
    apb(1'b1, ispf_pkg::ADDR_MASK, 32'h00000001);
    apb(1'b1, ispf_pkg::ADDR_CFG, 32'h00180003);
    apb(1'b1, ispf_pkg::ADDR_DATA, 32'h01ABCDEF);
    check({31'h0, e}, 32'h00000000);
    apb(1'b0, ispf_pkg::ADDR_DATA, 32'h0);
    check({31'h0, e}, 32'h00000001);
    chk_irq(1'b0);
    codec.frame(32'h0, 32'h0, 25, 1'b0);
    check(codec.got[0], 32'h01ABCDEF);
    check(codec.got[1], 32'h00000000);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check(q, 32'h00000005);
    chk_irq(1'b1);
    apb(1'b1, ispf_pkg::ADDR_MASK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, ispf_pkg::ADDR_MASK, 32'h00000001);
    chk_irq(1'b1);
    apb(1'b1, ispf_pkg::ADDR_STAT, 32'h00000001);
    apb(1'b0, ispf_pkg::ADDR_STAT, 32'h0);
    check(q, 32'h00000004);
    chk_irq(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reg_reset();
    foreach (lens[i])
    begin
      rx_len(lens[i], ispf_pkg::MODE_I2S);
      rx_len(lens[i], ispf_pkg::MODE_LJ);
    end
    rx_over();
    tx_under();
    mid_reset();
    test_done();
  end
  initial
  begin
    #2000000;
    n_fail++;
    test_done();
  end
endmodule
